/* eeprom_cmd_pkg.sv */
// Constants, command codes, register map and states of the single-wire EEPROM command block.
package eeprom_cmd_pkg;

	localparam int CLK_MHZ = 100;
	localparam int CNT_W   = 20;
	localparam int SP_AW   = 5;
	localparam int AR_AW   = 9;

	// Bus timing in microseconds; cycle counts follow from the clock rate.
	localparam int T_SMP_STD_US  = 30;
	localparam int T_SMP_OD_US   = 3;
	localparam int T_PDH_STD_US  = 15;
	localparam int T_PDH_OD_US   = 2;
	localparam int T_PDL_STD_US  = 60;
	localparam int T_PDL_OD_US   = 8;
	localparam int T_RST_STD_US  = 120;
	localparam int T_RST_OD_US   = 16;
	localparam int T_OD_EXIT_US  = 480;
	localparam int T_PROG_US     = 5000;

	localparam logic [CNT_W-1:0] SMP_STD_CYC = CNT_W'(T_SMP_STD_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] SMP_OD_CYC  = CNT_W'(T_SMP_OD_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] PDH_STD_CYC = CNT_W'(T_PDH_STD_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] PDH_OD_CYC  = CNT_W'(T_PDH_OD_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] PDL_OD_CYC  = CNT_W'(T_PDL_OD_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] RST_OD_CYC  = CNT_W'(T_RST_OD_US * CLK_MHZ);
	localparam int PDL_STD_CYC_D = T_PDL_STD_US * CLK_MHZ;
	localparam int RST_STD_CYC_D = T_RST_STD_US * CLK_MHZ;
	localparam int OD_EXIT_CYC_D = T_OD_EXIT_US * CLK_MHZ;
	localparam int PROG_CYC_D    = T_PROG_US * CLK_MHZ;

	localparam logic [7:0]  CMD_WRITE_SP = 8'h0f;
	localparam logic [7:0]  CMD_READ_SP  = 8'haa;
	localparam logic [7:0]  CMD_COPY_SP  = 8'h55;
	localparam logic [7:0]  CMD_READ_MEM = 8'hf0;
	localparam logic [7:0]  ROM_SEL_RST  = 8'hcc;
	localparam logic [7:0]  ALT_PATTERN  = 8'haa;
	localparam logic [7:0]  BLANK_BYTE   = 8'hff;
	localparam logic [15:0] CRC_POLY     = 16'ha001;
	localparam logic [4:0]  LAST_OFF     = 5'h1f;
	localparam logic        PF_RST       = 1'b1;

	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam logic [1:0] REG_ADDR = 2'h2;
	localparam int CTRL_OD_BIT  = 0;
	localparam int CTRL_ROM_LSB = 8;

	typedef enum logic [3:0] {
		S_IDLE, S_ROM, S_CMD, S_WS_ADDR, S_WS_DATA, S_WS_CRC, S_RS,
		S_CP_AUTH, S_CP_PROG, S_CP_DONE, S_RM_ADDR, S_RM_DATA
	} state_t;

endpackage : eeprom_cmd_pkg

/* eeprom_byte_mem.sv */
// Byte memory with one write port and a registered read port.
`timescale 1ns/1ps
module eeprom_byte_mem #(
	parameter int AW = 5
) (
	input  wire logic          clk_in,
	input  wire logic          resetn_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [7:0]    wdata_in,
	input  wire logic [AW-1:0] raddr_in,
	output logic      [7:0]    rdata_out
);
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_in)
	begin
		if (we_in)
			mem[waddr_in] <= wdata_in;
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rdata_out <= 8'h00;
		else
			rdata_out <= mem[raddr_in];
	end
endmodule : eeprom_byte_mem

/* eeprom_crc16.sv */
// Byte-wide CRC-16 accumulator, least significant bit first.
`timescale 1ns/1ps
module eeprom_crc16
	import eeprom_cmd_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        clr_in,
	input  wire logic        upd_in,
	input  wire logic [7:0]  data_in,
	output logic      [15:0] crc_out
);
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		return r;
	endfunction : crc_byte

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			crc_out <= 16'h0000;
		else if (upd_in)
			crc_out <= crc_byte(clr_in ? 16'h0000 : crc_out, data_in);
		else if (clr_in)
			crc_out <= 16'h0000;
	end
endmodule : eeprom_crc16

/* eeprom_cmd_top.sv */
// Memory-command layer of a single-wire-bus EEPROM slave with an Avalon-MM control port.
`timescale 1ns/1ps
module eeprom_cmd_top
	import eeprom_cmd_pkg::*;
#(
	parameter int RST_STD_CYC = RST_STD_CYC_D,
	parameter int OD_EXIT_CYC = OD_EXIT_CYC_D,
	parameter int PDL_STD_CYC = PDL_STD_CYC_D,
	parameter int PROG_CYC    = PROG_CYC_D
) (
	input  wire logic        sys_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        io_in,
	output logic             io_out,
	output logic             io_oe_out,
	input  wire logic [1:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out
);
	state_t           state;
	logic [CNT_W-1:0] low_cnt, slot_cnt, pres_cnt, prog_cnt;
	logic [CNT_W-1:0] smp_cyc, pdh_cyc, pdl_cyc, rst_cyc;
	logic             io_prev, od, rst_pend, pres_act, pres_drv, slot_on, wait_rise, rx_bit;
	logic             bit_ok, bit_val, byte_done, rst_hit, ld, tx_en, ack;
	logic [1:0]       ld_dly, idx;
	logic [2:0]       bitcnt;
	logic [7:0]       rx_sh, rx_byte, tx_byte, tx_src, ta_lo, ta_hi, rom_code, es;
	logic [7:0]       sp_rdata, ar_rdata, sp_wdata;
	logic [4:0]       es_e, wp, eng_off, eng_last, wr_off, sp_raddr, sp_waddr;
	logic [3:0]       eng_page;
	logic [9:0]       rm_ptr;
	logic             pf, aa, auth_ok, rd_past, rm_first, eng_act, eng_dir, wr_pend;
	logic             sp_we, ar_we, crc_clr, crc_upd, start_fill, prog_end;
	logic [15:0]      crc;
	logic [8:0]       ar_raddr;

	// States in which the device sends on read slots.
	function automatic logic sends(input state_t s);
		return s inside {S_RS, S_WS_CRC, S_RM_DATA, S_CP_DONE};
	endfunction : sends

	////////////////////////////////////////////////////////////////////////////
	// Slot timing

	always_comb
	begin
		smp_cyc = od ? SMP_OD_CYC : SMP_STD_CYC;
		pdh_cyc = od ? PDH_OD_CYC : PDH_STD_CYC;
		pdl_cyc = od ? PDL_OD_CYC : CNT_W'(PDL_STD_CYC);
		rst_cyc = od ? RST_OD_CYC : CNT_W'(RST_STD_CYC);
	end

	assign rst_hit   = ~io_in && (low_cnt == rst_cyc);
	assign bit_ok    = (slot_on && !wait_rise && slot_cnt == smp_cyc && io_in) ||
	                   (wait_rise && io_in && !io_prev);
	assign bit_val   = wait_rise ? rx_bit : 1'b1;
	assign byte_done = bit_ok && bitcnt == 3'd7;
	assign rx_byte   = {bit_val, rx_sh[7:1]};
	assign ld        = ld_dly[1];
	// Programming ends without a received byte, so it loads the first pattern byte itself.
	assign prog_end  = state == S_CP_PROG && !eng_act && !wr_pend &&
	                   prog_cnt == CNT_W'(PROG_CYC - 1);
	assign tx_en     = sends(state);
	assign pres_drv  = pres_act && pres_cnt >= pdh_cyc;
	assign io_out    = 1'b0;

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			io_prev <= 1'b1;
			low_cnt <= '0;
		end
		else
		begin
			io_prev <= io_in;
			if (io_in)
				low_cnt <= '0;
			else if (low_cnt != '1)
				low_cnt <= low_cnt + CNT_W'(1);
		end
	end

	// A long enough low phase resets the transfer; presence follows the release.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_pend <= 1'b0;
			pres_act <= 1'b0;
			pres_cnt <= '0;
		end
		else if (rst_hit)
			rst_pend <= 1'b1;
		else if (rst_pend && io_in)
		begin
			rst_pend <= 1'b0;
			pres_act <= 1'b1;
			pres_cnt <= '0;
		end
		else if (pres_act)
		begin
			pres_cnt <= pres_cnt + CNT_W'(1);
			if (pres_cnt == pdh_cyc + pdl_cyc)
				pres_act <= 1'b0;
		end
	end

	// A zero bit is committed only when the line rises again, so a reset pulse never
	// leaves a stray zero bit behind.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			slot_on   <= 1'b0;
			wait_rise <= 1'b0;
			slot_cnt  <= '0;
			rx_bit    <= 1'b1;
		end
		else if (rst_hit || pres_act)
		begin
			slot_on   <= 1'b0;
			wait_rise <= 1'b0;
		end
		else if (!slot_on && io_prev && !io_in)
		begin
			slot_on  <= 1'b1;
			slot_cnt <= '0;
		end
		else if (slot_on && !wait_rise)
		begin
			slot_cnt <= slot_cnt + CNT_W'(1);
			if (slot_cnt == smp_cyc)
			begin
				rx_bit    <= io_in;
				wait_rise <= ~io_in;
				slot_on   <= ~io_in;
			end
		end
		else if (wait_rise && io_in)
		begin
			wait_rise <= 1'b0;
			slot_on   <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			io_oe_out <= 1'b0;
		else
			io_oe_out <= pres_drv ||
			             (slot_on && !wait_rise && tx_en && !tx_byte[0]);
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bitcnt  <= 3'd0;
			rx_sh   <= 8'h00;
			ld_dly  <= 2'b00;
			tx_byte <= BLANK_BYTE;
		end
		else
		begin
			ld_dly <= {ld_dly[0], byte_done || prog_end};
			if (rst_hit)
				bitcnt <= 3'd0;
			else if (bit_ok)
			begin
				bitcnt <= bitcnt + 3'd1;
				rx_sh  <= rx_byte;
			end
			if (ld)
				tx_byte <= tx_src;
			else if (bit_ok)
				tx_byte <= {1'b1, tx_byte[7:1]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command interpreter

	assign es = {aa, 1'b0, pf, es_e};

	always_comb
	begin
		unique case (state)
			S_RS:      tx_src = (idx == 2'd0) ? ta_lo : (idx == 2'd1) ? ta_hi :
			                    (idx == 2'd2) ? es : rd_past ? BLANK_BYTE : sp_rdata;
			S_WS_CRC:  tx_src = (idx == 2'd0) ? ~crc[7:0] : ~crc[15:8];
			S_RM_DATA: tx_src = rm_ptr[9] ? BLANK_BYTE : ar_rdata;
			S_CP_DONE: tx_src = ALT_PATTERN;
			default:   tx_src = BLANK_BYTE;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state    <= S_IDLE;
			idx      <= 2'd0;
			ta_lo    <= 8'h00;
			ta_hi    <= 8'h00;
			es_e     <= 5'h00;
			wp       <= 5'h00;
			pf       <= PF_RST;
			aa       <= 1'b0;
			auth_ok  <= 1'b0;
			rd_past  <= 1'b0;
			rm_ptr   <= 10'h000;
			prog_cnt <= '0;
		end
		else if (rst_hit)
		begin
			if (state == S_WS_DATA && bitcnt != 3'd0)
				pf <= 1'b1;
			state <= S_ROM;
		end
		else if (state == S_CP_PROG)
		begin
			if (!eng_act && !wr_pend)
			begin
				prog_cnt <= prog_cnt + CNT_W'(1);
				if (prog_cnt == CNT_W'(PROG_CYC - 1))
					state <= S_CP_DONE;
			end
		end
		else if (byte_done)
		begin
			idx <= idx + 2'd1;
			unique case (state)
				S_IDLE, S_CP_DONE: ;
				S_ROM: state <= (rx_byte == rom_code) ? S_CMD : S_IDLE;
				S_CMD:
				begin
					idx <= 2'd0;
					unique case (rx_byte)
						CMD_WRITE_SP:
						begin
							state <= S_WS_ADDR;
							aa    <= 1'b0;
						end
						CMD_READ_SP:
						begin
							state   <= S_RS;
							wp      <= ta_lo[4:0];
							rd_past <= 1'b0;
						end
						CMD_COPY_SP:
						begin
							state   <= S_CP_AUTH;
							auth_ok <= 1'b1;
						end
						CMD_READ_MEM: state <= S_RM_ADDR;
						default: state <= S_IDLE;
					endcase
				end
				S_WS_ADDR, S_RM_ADDR:
					if (idx == 2'd0)
						ta_lo <= rx_byte;
					else
					begin
						ta_hi <= {7'h00, rx_byte[0]};
						if (state == S_WS_ADDR)
						begin
							es_e  <= ta_lo[4:0];
							wp    <= ta_lo[4:0];
							state <= S_WS_DATA;
						end
						else
						begin
							rm_ptr <= {1'b0, rx_byte[0], ta_lo};
							state  <= S_RM_DATA;
						end
					end
				S_WS_DATA:
				begin
					es_e <= wp;
					pf   <= 1'b0;
					wp   <= wp + 5'd1;
					idx  <= 2'd0;
					if (wp == LAST_OFF)
						state <= S_WS_CRC;
				end
				S_WS_CRC:
					if (idx == 2'd1)
						state <= S_IDLE;
				S_RS:
					if (idx == 2'd3)
					begin
						idx <= 2'd3;
						if (wp == LAST_OFF)
							rd_past <= 1'b1;
						else
							wp <= wp + 5'd1;
					end
				S_CP_AUTH:
				begin
					// Stored high byte is truncated, so a raw high address with any of bits 7:1 set never matches.
					auth_ok <= auth_ok && rx_byte == ((idx == 2'd0) ? ta_lo :
					           (idx == 2'd1) ? ta_hi : es);
					if (idx == 2'd2)
					begin
						if (auth_ok && rx_byte == es && ta_hi[7:1] == 7'h00)
						begin
							aa       <= 1'b1;
							prog_cnt <= '0;
							state    <= S_CP_PROG;
						end
						else
							state <= S_IDLE;
					end
				end
				S_RM_DATA:
					if (!rm_ptr[9])
						rm_ptr <= rm_ptr + 10'd1;
				default: state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Page copy engine: scratchpad to array, or array page into scratchpad

	assign start_fill = ld && state == S_RM_DATA && !rm_ptr[9] &&
	                    (rm_first || (rm_ptr[4:0] == LAST_OFF && rm_ptr[8:5] != 4'hf));

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			eng_act  <= 1'b0;
			eng_dir  <= 1'b0;
			eng_off  <= 5'h00;
			eng_last <= 5'h00;
			eng_page <= 4'h0;
			wr_pend  <= 1'b0;
			wr_off   <= 5'h00;
			rm_first <= 1'b0;
		end
		else
		begin
			wr_pend <= eng_act;
			wr_off  <= eng_off;
			if (byte_done && state == S_RM_ADDR && idx == 2'd1)
				rm_first <= 1'b1;
			else if (ld)
				rm_first <= 1'b0;
			if (byte_done && state == S_CP_AUTH && idx == 2'd2 && auth_ok && rx_byte == es)
			begin
				eng_act  <= 1'b1;
				eng_dir  <= 1'b0;
				eng_off  <= ta_lo[4:0];
				eng_last <= es_e;
				eng_page <= {ta_hi[0], ta_lo[7:5]};
			end
			else if (start_fill)
			begin
				eng_act  <= 1'b1;
				eng_dir  <= 1'b1;
				eng_off  <= 5'h00;
				eng_last <= LAST_OFF;
				eng_page <= rm_first ? rm_ptr[8:5] : rm_ptr[8:5] + 4'h1;
			end
			else if (eng_act)
			begin
				eng_off <= eng_off + 5'd1;
				if (eng_off == eng_last)
					eng_act <= 1'b0;
			end
		end
	end

	assign sp_we    = (wr_pend && eng_dir) || (byte_done && state == S_WS_DATA);
	assign sp_waddr = wr_pend ? wr_off : wp;
	assign sp_wdata = wr_pend ? ar_rdata : rx_byte;
	assign sp_raddr = (eng_act && !eng_dir) ? eng_off : wp;
	assign ar_we    = wr_pend && !eng_dir;
	assign ar_raddr = (eng_act && eng_dir) ? {eng_page, eng_off} : rm_ptr[8:0];
	assign crc_clr  = byte_done && state == S_CMD;
	assign crc_upd  = byte_done && ((state == S_CMD && rx_byte == CMD_WRITE_SP) ||
	                  state == S_WS_ADDR || state == S_WS_DATA);

	eeprom_byte_mem #(.AW(SP_AW)) u_scratch (
		.clk_in    (sys_clk_in),
		.resetn_in (resetn_in),
		.we_in     (sp_we),
		.waddr_in  (sp_waddr),
		.wdata_in  (sp_wdata),
		.raddr_in  (sp_raddr),
		.rdata_out (sp_rdata)
	);

	eeprom_byte_mem #(.AW(AR_AW)) u_array (
		.clk_in    (sys_clk_in),
		.resetn_in (resetn_in),
		.we_in     (ar_we),
		.waddr_in  ({eng_page, wr_off}),
		.wdata_in  (sp_rdata),
		.raddr_in  (ar_raddr),
		.rdata_out (ar_rdata)
	);

	eeprom_crc16 u_crc (
		.clk_in    (sys_clk_in),
		.resetn_in (resetn_in),
		.clr_in    (crc_clr),
		.upd_in    (crc_upd),
		.data_in   (rx_byte),
		.crc_out   (crc)
	);

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: every access answers on the second cycle

	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ack              <= 1'b0;
			avs_readdata_out <= 32'h0000_0000;
		end
		else
		begin
			ack <= (avs_read_in || avs_write_in) && !ack;
			unique case (avs_address_in)
				REG_CTRL: avs_readdata_out <= {16'h0000, rom_code, 7'h00, od};
				REG_STAT: avs_readdata_out <= {24'h000000, eng_act, 4'(state), 1'b0,
				                               pres_act, rst_pend};
				REG_ADDR: avs_readdata_out <= {8'h00, es, ta_hi, ta_lo};
				default:  avs_readdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Software may select fast timing; a very long reset pulse returns to standard.
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			od       <= 1'b0;
			rom_code <= ROM_SEL_RST;
		end
		else if (avs_write_in && ack && avs_address_in == REG_CTRL)
		begin
			od       <= avs_writedata_in[CTRL_OD_BIT];
			rom_code <= avs_writedata_in[CTRL_ROM_LSB +: 8];
		end
		else if (!io_in && low_cnt == CNT_W'(OD_EXIT_CYC))
			od <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	a_trunc_high: assert property (byte_done && state == S_WS_ADDR && idx == 2'd1
		|=> ta_hi[7:1] == 7'h00) else $error("high address bits not cleared");
	a_end_load: assert property (byte_done && state == S_WS_ADDR && idx == 2'd1
		|=> es_e == $past(ta_lo[4:0])) else $error("ending offset not loaded");
	a_pf_partial: assert property (rst_hit && state == S_WS_DATA && bitcnt != 3'd0
		|=> pf && state == S_ROM) else $error("partial byte not flagged");
	a_crc_inv: assert property (ld && state == S_WS_CRC && idx == 2'd0
		|=> tx_byte == ~crc[7:0]) else $error("crc low byte not inverted");
	a_auth_bad: assert property (byte_done && state == S_CP_AUTH && idx == 2'd2 && !auth_ok
		|=> state == S_IDLE && !eng_act) else $error("bad authorization accepted");
	a_copy_go: assert property (byte_done && state == S_CP_AUTH && idx == 2'd2 && auth_ok &&
		rx_byte == es |=> aa && eng_act ##1 wr_pend) else $error("copy not started");
	a_alt_pat: assert property (ld && state == S_CP_DONE
		|=> tx_byte == ALT_PATTERN) else $error("alternating pattern missing");
	a_sp_blank: assert property (ld && state == S_RS && idx == 2'd3 && rd_past
		|=> tx_byte == BLANK_BYTE) else $error("scratchpad overrun not all ones");
	a_rm_blank: assert property (ld && state == S_RM_DATA && rm_ptr[9]
		|=> tx_byte == BLANK_BYTE) else $error("array overrun not all ones");
	a_abort_cmd: assert property (rst_hit |=> state == S_ROM [*2])
		else $error("reset pulse did not abort command");
	a_ws_clr_aa: assert property (byte_done && state == S_CMD && rx_byte == CMD_WRITE_SP
		|=> !aa && state == S_WS_ADDR) else $error("authorized flag not cleared");

	c_copy_done: cover property (state == S_CP_DONE && ld);
	c_crc_sent:  cover property (state == S_WS_CRC && ld);
	c_rm_past:   cover property (state == S_RM_DATA && rm_ptr[9]);
	c_presence:  cover property (pres_drv);
endmodule : eeprom_cmd_top

/* wire_master_model.sv */
// Behavioural single-wire bus master that drives the line through an open-drain pulldown.
`timescale 1ns/1ps
module wire_master_model (
	input  wire logic clk_in,
	input  wire logic dev_pull_in,
	output logic      line_out
);
	logic pull = 1'b0;

	// Nobody pulling means the pull-up holds the idle line high.
	assign line_out = !(pull || dev_pull_in);

	////////////////////////////////////////////////////////////////////////////////
	task automatic slot(input logic b, output logic r);
		pull <= 1'b1;
		repeat (5) @(posedge clk_in);
		if (b)
			pull <= 1'b0;
		repeat (200) @(posedge clk_in);
		r = line_out;
		repeat (105) @(posedge clk_in);
		pull <= 1'b0;
		repeat (5) @(posedge clk_in);
	endtask : slot

	task automatic wbyte(input logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) slot(d[i], r);
	endtask : wbyte

	task automatic rbyte(output logic [7:0] d);
		for (int i = 0; i < 8; i++) slot(1'b1, d[i]);
	endtask : rbyte

	// The low time stays below the fast-exit length, so fast timing survives.
	task automatic reset_pulse(output logic pres);
		pull <= 1'b1;
		repeat (1700) @(posedge clk_in);
		pull <= 1'b0;
		repeat (400) @(posedge clk_in);
		pres = !line_out;
		repeat (800) @(posedge clk_in);
	endtask : reset_pulse
endmodule : wire_master_model

/* tb_single_wire_eeprom_memory_commands.sv */
// Self-checking bench for the single-wire EEPROM memory-command block.
`timescale 1ns/1ps
module tb_single_wire_eeprom_memory_commands;
	logic        clk;
	logic        resetn;
	logic [1:0]  address;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic        line;
	logic        dev_pull;
	logic        io_val;
	logic        bit_r;
	logic [31:0] q;
	logic [7:0]  d[3];
	logic [7:0]  ws[$];
	logic [15:0] crc;
	int          err_count = 0;
	int          check_count = 0;
	int          seed = 32'h50cba451;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	eeprom_cmd_top #(.PROG_CYC(50)) dut (
		.sys_clk_in          (clk),
		.resetn_in           (resetn),
		.io_in               (line),
		.io_out              (io_val),
		.io_oe_out           (dev_pull),
		.avs_address_in      (address),
		.avs_read_in         (rd),
		.avs_write_in        (wr),
		.avs_writedata_in    (wdata),
		.avs_readdata_out    (rdata),
		.avs_waitrequest_out (waitreq)
	);

	wire_master_model master (.clk_in(clk), .dev_pull_in(dev_pull), .line_out(line));

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic av(input logic [1:0] a, input logic w, input logic [31:0] wd);
		int n;
		address <= a;
		wr <= w;
		rd <= !w;
		wdata <= wd;
		@(posedge clk);
		for (n = 0; n < 50 && waitreq !== 1'b0; n++) @(posedge clk);
		if (waitreq !== 1'b0)
		begin
			err_count++;
			$display("[FAIL] %0t bus wait timed out", $time);
			give_verdict();
		end
		// Read here, before the edge's updates land, so these are the values sampled at it.
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		// One idle edge keeps the next request from reassigning rd and wr in this time step.
		@(posedge clk);
	endtask : av

	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) master.wbyte(b[i]);
	endtask : send

	task automatic expect_byte(input logic [7:0] e);
		logic [7:0] g;
		master.rbyte(g);
		chk({24'h0, g}, {24'h0, e});
	endtask : expect_byte

	task automatic init();
		logic pres;
		master.reset_pulse(pres);
		chk(32'(pres), 32'h1);
		send('{8'hcc});
	endtask : init

	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'ha001 : c >> 1;
		return c;
	endfunction : crc16

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		address = 2'h0;
		wdata = 32'h0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		av(2'h0, 1'b0, 32'h0);
		chk(q, 32'h0000cc00);
		av(2'h3, 1'b1, 32'hffffffff);
		av(2'h3, 1'b0, 32'h0);
		chk(q, 32'h0);
		av(2'h2, 1'b0, 32'h0);
		chk(32'(q[21]), 32'h1);
		// Fast timing keeps the run short; slow slots cost ten times as much.
		av(2'h0, 1'b1, 32'h0000cc01);
		av(2'h0, 1'b0, 32'h0);
		chk(q, 32'h0000cc01);
		for (int i = 0; i < 3; i++) d[i] = 8'($random(seed));
		ws = '{8'h0f, 8'hfd, 8'hff, d[0], d[1], d[2]};
		crc = 16'h0;
		foreach (ws[i]) crc = crc16(crc, ws[i]);
		init();
		send(ws);
		expect_byte(~crc[7:0]);
		expect_byte(~crc[15:8]);
		init();
		send('{8'haa});
		expect_byte(8'hfd);
		expect_byte(8'h01);
		expect_byte(8'h1f);
		foreach (d[i]) expect_byte(d[i]);
		expect_byte(8'hff);
		init();
		send('{8'h55, 8'hfd, 8'hff, 8'h1f});
		av(2'h2, 1'b0, 32'h0);
		chk(32'(q[23:16]), 32'h1f);
		init();
		send('{8'h55, 8'hfd, 8'h01, 8'h1f});
		repeat (100) @(posedge clk);
		expect_byte(8'haa);
		av(2'h2, 1'b0, 32'h0);
		chk(32'(q[23:0]), 32'h009f01fd);
		init();
		send('{8'hf0, 8'hfe, 8'h81});
		expect_byte(d[1]);
		expect_byte(d[2]);
		expect_byte(8'hff);
		av(2'h2, 1'b0, 32'h0);
		chk(32'(q[15:0]), 32'h01fe);
		init();
		// A write cut three bits into its first data byte must leave the flag set.
		send('{8'h0f, 8'h1e, 8'h00});
		repeat (3) master.slot(1'b1, bit_r);
		init();
		av(2'h2, 1'b0, 32'h0);
		chk(32'(q[23:0]), 32'h003e001e);
		chk(32'(io_val), 32'h0);
		give_verdict();
	end
endmodule : tb_single_wire_eeprom_memory_commands
